// File: hw/wdc_pkg.sv
// Purpose: Constants for the watchdog down counter
// Assumes: Word-addressed register port, 16-bit data
// Notes: Summary of operation below
package wdc_pkg;
	localparam logic [1:0] WDC_ADDR_CTRL = 2'h0;
	localparam logic [1:0] WDC_ADDR_TOUT = 2'h1;
	localparam logic [1:0] WDC_ADDR_CNT = 2'h2;
	localparam int WDC_PSS_HI = 9;
	localparam int WDC_PSS_LO = 8;
	localparam int WDC_CSEL_HI = 6;
	localparam int WDC_CSEL_LO = 5;
	localparam int WDC_LOR_BIT = 4;
	localparam int WDC_SRUN_BIT = 3;
	localparam int WDC_WRUN_BIT = 2;
	localparam int WDC_EN_BIT = 1;
	localparam int WDC_WP_BIT = 0;
	localparam logic [15:0] WDC_CTRL_RST = 16'h0302;
	localparam logic [15:0] WDC_TOUT_RST = 16'hFFFF;
	localparam logic [15:0] WDC_SVC_FIRST = 16'h5555;
	localparam logic [15:0] WDC_SVC_SECOND = 16'hAAAA;
	localparam logic [6:0] WDC_LOR_LAST = 7'h7F;
	localparam logic [9:0] WDC_DIV16_LAST = 10'h00F;
	localparam logic [9:0] WDC_DIV256_LAST = 10'h0FF;
	localparam logic [9:0] WDC_DIV1024_LAST = 10'h3FF;
endpackage : wdc_pkg

// File: hw/wdc_top.sv
// Purpose: Watchdog down counter with prescaler, service sequence and loss-of-reference reset
// Assumes: Clock sources arrive as levels sampled on ref_clk_i; power-down recovery is signalled by ppd_recover_i
// Notes: Source edges are detected in the 50 MHz domain, so sources must be well below 25 MHz
`timescale 1ns/1ps
module wdc_top
	import wdc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ppd_recover_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	input wire logic relaxation_osc_i,
	input wire logic crystal_osc_i,
	input wire logic lpo_1khz_i,
	input wire logic debug_i,
	input wire logic wait_i,
	input wire logic stop_i,
	input wire logic partial_power_down_i,
	input wire logic ref_loss_i,
	output logic chip_reset_o,
	output logic wdog_rst_n_o,
	output logic lor_reset_o
);
	logic [15:0] ctrl_ff;
	logic [15:0] nxt_ctrl;
	logic [15:0] tout_ff;
	logic [15:0] nxt_tout;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic armed_ff;
	logic nxt_armed;
	logic [9:0] pre_ff;
	logic [9:0] nxt_pre;
	logic src_ff;
	logic [6:0] lor_ff;
	logic [6:0] nxt_lor;
	logic lor_run_ff;
	logic nxt_lor_run;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic to_ff;
	logic ppd_to_ff;
	logic lor_rst_ff;

	// Reset is ignored while recovering from power-down so settings survive
	wire do_rst = !rstn_i && !ppd_recover_i;
	wire wp = ctrl_ff[WDC_WP_BIT];
	wire en = ctrl_ff[WDC_EN_BIT];
	wire wr_ctrl = reg_wr_i && reg_addr_i == WDC_ADDR_CTRL && !wp;
	wire wr_tout = reg_wr_i && reg_addr_i == WDC_ADDR_TOUT && !wp;
	wire wr_cnt = reg_wr_i && reg_addr_i == WDC_ADDR_CNT;
	// Service completes only on the second pattern after an armed first one
	wire svc_done = wr_cnt && armed_ff && reg_wdata_i == WDC_SVC_SECOND;

	// Source selection
	wire [1:0] csel = ctrl_ff[WDC_CSEL_HI:WDC_CSEL_LO];
	wire src_lvl = csel == 2'h0 ? relaxation_osc_i :
		csel == 2'h1 ? crystal_osc_i :
		csel == 2'h2 ? 1'b1 : lpo_1khz_i;
	wire src_rise = csel == 2'h2 ? 1'b1 : (src_lvl && !src_ff);

	// Prescaler terminal count by field
	wire [1:0] prescale_select = ctrl_ff[WDC_PSS_HI:WDC_PSS_LO];
	wire [9:0] pre_last = prescale_select == 2'h0 ? 10'h000 :
		prescale_select == 2'h1 ? WDC_DIV16_LAST :
		prescale_select == 2'h2 ? WDC_DIV256_LAST : WDC_DIV1024_LAST;
	wire pre_tick = src_rise && pre_ff >= pre_last;

	// Low-power modes need both the run bit and enable to keep counting
	wire in_stop = stop_i || partial_power_down_i;
	wire allowed = en && !debug_i
		&& (!in_stop || ctrl_ff[WDC_SRUN_BIT])
		&& (!wait_i || ctrl_ff[WDC_WRUN_BIT]);
	wire halt_reload = (in_stop && !(en && ctrl_ff[WDC_SRUN_BIT]))
		|| (wait_i && !(en && ctrl_ff[WDC_WRUN_BIT]));
	wire count_tick = allowed && pre_tick && !to_ff;

	// Register updates
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		nxt_tout = tout_ff;
		nxt_armed = armed_ff;
		if (wr_ctrl)
			nxt_ctrl = {6'h00, reg_wdata_i[9:8], 1'b0, reg_wdata_i[6:0]};
		if (wp)
			nxt_ctrl[WDC_WP_BIT] = 1'b1;
		if (wr_tout)
			nxt_tout = reg_wdata_i;
		if (wr_cnt)
			nxt_armed = reg_wdata_i == WDC_SVC_FIRST;
	end

	// Down counter: reload on service, halt or disable; one step per prescaled edge
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_pre = pre_ff;
		if (src_rise && allowed)
			nxt_pre = pre_tick ? 10'h000 : pre_ff + 10'h001;
		if (svc_done || halt_reload || !en)
		begin
			nxt_cnt = tout_ff;
			nxt_pre = 10'h000;
		end
		else if (count_tick && cnt_ff != 16'h0000)
			nxt_cnt = cnt_ff - 16'h0001;
	end

	// Loss-of-reference counter keeps running once started; service restarts it
	always_comb
	begin
		nxt_lor = lor_ff;
		nxt_lor_run = lor_run_ff;
		if (!ctrl_ff[WDC_LOR_BIT])
		begin
			nxt_lor = 7'h00;
			nxt_lor_run = 1'b0;
		end
		else
		begin
			if (ref_loss_i)
				nxt_lor_run = 1'b1;
			if (svc_done)
				nxt_lor = 7'h00;
			else if (lor_run_ff && lor_ff != WDC_LOR_LAST)
				nxt_lor = lor_ff + 7'h01;
		end
	end

	// Read data; enable reads as zero in debug
	always_comb
	begin
		nxt_rdata = 16'h0000;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				WDC_ADDR_CTRL:
				begin
					nxt_rdata = ctrl_ff;
					if (debug_i)
						nxt_rdata[WDC_EN_BIT] = 1'b0;
				end
				WDC_ADDR_TOUT: nxt_rdata = tout_ff;
				WDC_ADDR_CNT: nxt_rdata = cnt_ff;
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	// Control and settings
	always_ff @(posedge ref_clk_i)
	begin
		if (do_rst)
		begin
			ctrl_ff <= WDC_CTRL_RST;
			tout_ff <= WDC_TOUT_RST;
			cnt_ff <= WDC_TOUT_RST;
			armed_ff <= 1'b0;
			pre_ff <= 10'h000;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			tout_ff <= nxt_tout;
			cnt_ff <= nxt_cnt;
			armed_ff <= nxt_armed;
			pre_ff <= nxt_pre;
		end
	end

	// Status and outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (do_rst)
		begin
			src_ff <= 1'b0;
			lor_ff <= 7'h00;
			lor_run_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			to_ff <= 1'b0;
			ppd_to_ff <= 1'b0;
			lor_rst_ff <= 1'b0;
		end
		else
		begin
			src_ff <= src_lvl;
			lor_ff <= nxt_lor;
			lor_run_ff <= nxt_lor_run;
			rdata_ff <= nxt_rdata;
			to_ff <= en && !debug_i && cnt_ff == 16'h0000;
			ppd_to_ff <= partial_power_down_i && en && cnt_ff == 16'h0000;
			lor_rst_ff <= ctrl_ff[WDC_LOR_BIT] && lor_ff == WDC_LOR_LAST;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign chip_reset_o = to_ff;
	assign wdog_rst_n_o = !ppd_to_ff;
	assign lor_reset_o = lor_rst_ff;

	// Checks: all are cut off by the module reset, so the reload that reset performs is never judged
	// A mid-run reset during power-down recovery leaves do_rst low, so checks keep running through it

	// Protected registers must not move at all once locked
	AST_WP_HOLDS: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		wp |=> $stable(ctrl_ff) && $stable(tout_ff))
		else $error("protected regs changed");

	// Lock bit is sticky until module reset
	AST_WP_STICKY: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		wp |=> wp)
		else $error("write protect cleared");

	// Unlocked control write lands its prescale field
	AST_CTRL_WRITE: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		wr_ctrl |=> ctrl_ff[WDC_PSS_HI:WDC_PSS_LO] == $past(reg_wdata_i[9:8]))
		else $error("control write lost");

	// Unlocked timeout write lands whole
	AST_TOUT_WRITE: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		wr_tout |=> tout_ff == $past(reg_wdata_i))
		else $error("timeout write lost");

	// Reserved control bits never hold a one
	AST_RESERVED_ZERO: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		ctrl_ff[15:10] == 6'h00 && !ctrl_ff[7])
		else $error("reserved control bit set");

	// Completed service pair reloads from the timeout value
	AST_SVC_RELOAD: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		svc_done |=> cnt_ff == $past(tout_ff))
		else $error("service did not reload");

	// First pattern always arms the pair
	AST_ARM_FIRST: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(wr_cnt && reg_wdata_i == WDC_SVC_FIRST) |=> armed_ff)
		else $error("first pattern did not arm");

	// Accesses elsewhere keep the pair armed
	AST_ARM_KEEP: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(armed_ff && !wr_cnt) |=> armed_ff)
		else $error("arm lost without count write");

	// A second pattern without arming only counts on as usual
	AST_LONE_SECOND: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(wr_cnt && !armed_ff && !halt_reload && count_tick && cnt_ff != 16'h0000)
		|=> cnt_ff == $past(cnt_ff) - 16'h0001)
		else $error("unarmed write changed count");

	// Zero count with the counter live raises chip reset
	AST_ZERO_RESET: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(en && !debug_i && cnt_ff == 16'h0000) |=> chip_reset_o)
		else $error("no reset at zero");

	// After timeout the count stays put until serviced, disabled or halted by a low-power mode
	AST_TIMEOUT_FREEZE: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(to_ff && en && !svc_done && !halt_reload) |=> $stable(cnt_ff))
		else $error("count moved after timeout");

	// Debug freezes the count
	AST_DEBUG_HOLD: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(debug_i && en && !svc_done && !halt_reload) |=> $stable(cnt_ff))
		else $error("counted in debug");

	// Debug never lets the timeout reach the chip
	AST_DEBUG_NO_RESET: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		debug_i |=> !chip_reset_o)
		else $error("reset issued in debug");

	// Enable bit reads as zero in debug
	AST_DEBUG_READ: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(reg_rd_i && reg_addr_i == WDC_ADDR_CTRL && debug_i) |=> !reg_rdata_o[WDC_EN_BIT])
		else $error("enable visible in debug");

	// Count register reads the live count
	AST_CNT_READ: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(reg_rd_i && reg_addr_i == WDC_ADDR_CNT) |=> reg_rdata_o == $past(cnt_ff))
		else $error("count read wrong");

	// Read data is zero outside the answer cycle
	AST_NO_READ_ZERO: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data without read");

	// Stop without run permission reloads
	AST_STOP_RELOAD: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(stop_i && !ctrl_ff[WDC_SRUN_BIT]) |=> cnt_ff == $past(tout_ff))
		else $error("stop did not reload");

	// Wait without run permission reloads
	AST_WAIT_RELOAD: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(wait_i && !ctrl_ff[WDC_WRUN_BIT]) |=> cnt_ff == $past(tout_ff))
		else $error("wait did not reload");

	// Disabled counter sits at the timeout value, so re-enabling starts a full period
	AST_ENABLE_OFF_RELOAD: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		!en |=> cnt_ff == $past(tout_ff))
		else $error("disabled count not reloaded");

	// One step per prescaled edge
	AST_STEP_ONE: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(count_tick && !svc_done && !halt_reload && cnt_ff != 16'h0000)
		|=> cnt_ff == $past(cnt_ff) - 16'h0001)
		else $error("bad decrement");

	// Loss-of-reference reset needs its enable
	AST_LOR_OFF: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		!ctrl_ff[WDC_LOR_BIT] |=> !lor_reset_o)
		else $error("lor reset while disabled");

	// Terminal loss count raises the reset
	AST_LOR_TIME: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(ctrl_ff[WDC_LOR_BIT] && lor_ff == WDC_LOR_LAST) |=> lor_reset_o)
		else $error("lor reset missing");

	// Running loss counter steps by one each cycle
	AST_LOR_STEP: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(ctrl_ff[WDC_LOR_BIT] && lor_run_ff && !svc_done && lor_ff != WDC_LOR_LAST)
		|=> lor_ff == $past(lor_ff) + 7'h01)
		else $error("lor count step wrong");

	// Service restarts the loss counter
	AST_LOR_CLEAR: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(ctrl_ff[WDC_LOR_BIT] && svc_done) |=> lor_ff == 7'h00)
		else $error("service did not restart lor");

	// Timeout in power-down pulls the wake line low
	AST_PPD_WAKE: assert property (@(posedge ref_clk_i) disable iff (do_rst)
		(partial_power_down_i && en && cnt_ff == 16'h0000) |=> !wdog_rst_n_o)
		else $error("no wake reset");

	// Main scenarios
	COV_SERVICE: cover property (@(posedge ref_clk_i) svc_done);
	// Timeout reached
	COV_TIMEOUT: cover property (@(posedge ref_clk_i) chip_reset_o);
	// Loss-of-reference reset reached
	COV_LOR: cover property (@(posedge ref_clk_i) lor_reset_o);
	// Write attempted while locked
	COV_PROTECT: cover property (@(posedge ref_clk_i) wp && reg_wr_i);
	// Wakeup from power-down
	COV_PPD_WAKE: cover property (@(posedge ref_clk_i) !wdog_rst_n_o);
endmodule : wdc_top

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the watchdog down counter
// Assumes: Bus clock is the count source until the final 1 kHz test; undivided it gives one count step per 50 MHz cycle
// Notes: Reads queue their expected word; a monitor checks each one when it appears
`timescale 1ns/1ps
module tb_top;
	import wdc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ppd_recover_i = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [15:0] reg_rdata_o;
	logic relaxation_osc_i = 1'b0, crystal_osc_i = 1'b0, lpo_1khz_i = 1'b0;
	logic debug_i = 1'b0, wait_i = 1'b0, stop_i = 1'b0, partial_power_down_i = 1'b0, ref_loss_i = 1'b0;
	logic chip_reset_o, wdog_rst_n_o, lor_reset_o;
	logic rd_pend = 1'b0;
	logic [15:0] exp_q[$];
	logic [15:0] t;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 3421;
	int n;

	wdc_top i_dut (.ref_clk_i, .rstn_i, .ppd_recover_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
		.reg_rdata_o, .relaxation_osc_i, .crystal_osc_i, .lpo_1khz_i, .debug_i, .wait_i, .stop_i,
		.partial_power_down_i, .ref_loss_i, .chip_reset_o, .wdog_rst_n_o, .lor_reset_o);

	// Free-running 50 MHz clock
	initial forever #10 ref_clk_i = ~ref_clk_i;

	// Noisy oscillator levels keep the unselected sources from hiding a wrong select decode
	always @(posedge ref_clk_i)
		#1 {relaxation_osc_i, crystal_osc_i, lpo_1khz_i} = 3'($random(seed));

	task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp16

	task automatic chk_flag(input string nm, input logic e, input logic s);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask : chk_flag

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask : cyc

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		#1 reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		cyc(1);
		reg_wr_i = 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge ref_clk_i);
		#1 reg_addr_i = a;
		reg_rd_i = 1'b1;
		exp_q.push_back(e);
		cyc(1);
		reg_rd_i = 1'b0;
	endtask : rd

	// Bounded wait for 0 chip reset, 1 loss-of-reference reset, 2 low wakeup reset
	task automatic wait_out(input int which, input int lim);
		n = 0;
		while ((which == 0 ? chip_reset_o : which == 1 ? lor_reset_o : !wdog_rst_n_o) !== 1'b1 && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask : wait_out

	task automatic final_report;
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// Read data stands for one cycle only, so it is checked at the falling edge after the read
	always @(posedge ref_clk_i)
		rd_pend <= reg_rd_i;
	always @(negedge ref_clk_i)
		if (rd_pend)
			cmp16("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);

	// Hang guard, far above the fewer than one thousand cycles the sequence needs
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			final_report();
		end
	end

	initial
	begin
		t = 16'(40 + ($random(seed) & 63));
		cyc(20);
		rstn_i = 1'b1;
		rd(WDC_ADDR_CTRL, WDC_CTRL_RST);
		rd(WDC_ADDR_TOUT, WDC_TOUT_RST);
		rd(WDC_ADDR_CNT, 16'hFFFF);
		rd(2'h3, 16'h0000);
		wr(WDC_ADDR_CTRL, 16'h0300);
		wr(WDC_ADDR_CTRL, 16'h0040);
		wr(WDC_ADDR_TOUT, t);
		rd(WDC_ADDR_TOUT, t);
		rd(WDC_ADDR_CNT, t);
		debug_i = 1'b1;
		wr(WDC_ADDR_CTRL, 16'h0042);
		cyc(10);
		rd(WDC_ADDR_CNT, t);
		rd(WDC_ADDR_CTRL, 16'h0040);
		wait_i = 1'b1;
		debug_i = 1'b0;
		cyc(10);
		rd(WDC_ADDR_CNT, t);
		stop_i = 1'b1;
		wait_i = 1'b0;
		cyc(10);
		rd(WDC_ADDR_CNT, t);
		stop_i = 1'b0;
		cyc(t / 2);
		// A lone second pattern must not reload; the unmapped read between the pair must not disarm
		wr(WDC_ADDR_CNT, WDC_SVC_SECOND);
		wr(WDC_ADDR_CNT, WDC_SVC_FIRST);
		rd(2'h3, 16'h0000);
		wr(WDC_ADDR_CNT, WDC_SVC_SECOND);
		cyc(t - 4);
		chk_flag("chip_reset_o", 1'b0, chip_reset_o);
		wait_out(0, 12);
		chk_flag("chip_reset_o", 1'b1, chip_reset_o);
		wr(WDC_ADDR_CTRL, 16'h0041);
		wr(WDC_ADDR_TOUT, 16'h1234);
		wr(WDC_ADDR_CTRL, 16'h0000);
		rd(WDC_ADDR_CTRL, 16'h0041);
		rd(WDC_ADDR_TOUT, t);
		ppd_recover_i = 1'b1;
		rstn_i = 1'b0;
		cyc(2);
		rstn_i = 1'b1;
		ppd_recover_i = 1'b0;
		rd(WDC_ADDR_TOUT, t);
		rstn_i = 1'b0;
		cyc(2);
		rstn_i = 1'b1;
		rd(WDC_ADDR_CTRL, WDC_CTRL_RST);
		wr(WDC_ADDR_CTRL, 16'h0050);
		ref_loss_i = 1'b1;
		cyc(1);
		ref_loss_i = 1'b0;
		cyc(110);
		chk_flag("lor_reset_o", 1'b0, lor_reset_o);
		wait_out(1, 30);
		chk_flag("lor_reset_o", 1'b1, lor_reset_o);
		// Divide by 16 with timeout 3 must outlast 40 cycles yet end well inside 80
		wr(WDC_ADDR_TOUT, 16'h0003);
		wr(WDC_ADDR_CTRL, 16'h0142);
		cyc(40);
		chk_flag("chip_reset_o", 1'b0, chip_reset_o);
		wait_out(0, 40);
		chk_flag("chip_reset_o", 1'b1, chip_reset_o);
		// Disable before moving to the 1 kHz source, then reprogram the timeout
		wr(WDC_ADDR_CTRL, 16'h0140);
		wr(WDC_ADDR_CTRL, 16'h0068);
		wr(WDC_ADDR_TOUT, 16'h0020);
		stop_i = 1'b1;
		partial_power_down_i = 1'b1;
		cyc(40);
		chk_flag("wdog_rst_n_o", 1'b1, wdog_rst_n_o);
		wr(WDC_ADDR_CTRL, 16'h006A);
		wait_out(2, 400);
		chk_flag("wdog_rst_n_o", 1'b0, wdog_rst_n_o);
		cyc(4);
		final_report();
	end
endmodule : tb_top
